// *** src/ocd_regs.svh ***
// Option byte layout, reset values and decode codes
`ifndef OCD_REGS_SVH
`define OCD_REGS_SVH

// Option byte select on the programming port
`define OCD_SEL_OPT0      1'b0
`define OCD_SEL_OPT1      1'b1

// Unprogrammed storage reads as all ones
`define OCD_OPT_RESET     8'hFF

// Byte 0 fields
`define OCD_B0_RSV_HI     7
`define OCD_B0_RSV_LO     2
`define OCD_B0_PKG        1
`define OCD_B0_PROT       0

// Byte 1 fields
`define OCD_B1_CSS        7
`define OCD_B1_OSC_HI     6
`define OCD_B1_OSC_LO     4
`define OCD_B1_LVD_HI     3
`define OCD_B1_LVD_LO     2
`define OCD_B1_HALT       1
`define OCD_B1_SW         0

// Oscillator field codes
`define OCD_OSC_EXT_CLK   3'h7
`define OCD_OSC_INT_RC    3'h6
`define OCD_OSC_EXT_RC0   3'h5
`define OCD_OSC_EXT_RC1   3'h4
`define OCD_OSC_LP        3'h3
`define OCD_OSC_MP        3'h2
`define OCD_OSC_MS        3'h1
`define OCD_OSC_HS        3'h0

// Brownout field codes
`define OCD_LVD_OFF       2'h3
`define OCD_LVD_HIGH      2'h2
`define OCD_LVD_MED       2'h1
`define OCD_LVD_LOW       2'h0

// Program memory size swept by the erase engine
`define OCD_PMEM_BYTES    16384
`define OCD_PMEM_AW       14

`endif

// *** src/ocd_pkg.sv ***
// Types shared by the option byte decoder
`default_nettype none
package ocd_pkg;
  typedef enum logic [2:0] {
    OCD_OSC_HS_T, OCD_OSC_MS_T, OCD_OSC_MP_T, OCD_OSC_LP_T,
    OCD_OSC_EXT_RC_T, OCD_OSC_INT_RC_T, OCD_OSC_EXT_CLK_T
  } ocd_osc_t;
  typedef enum logic [1:0] {
    OCD_LVD_LOW_T, OCD_LVD_MED_T, OCD_LVD_HIGH_T, OCD_LVD_NONE_T
  } ocd_lvd_t;
  typedef enum logic {
    OCD_ER_IDLE, OCD_ER_RUN
  } ocd_erase_st_t;
endpackage
`default_nettype wire

// *** src/ocd_cfg_if.sv ***
// Carrier between option storage and the byte 1 field decoder
`default_nettype none
interface ocd_cfg_if;
  import ocd_pkg::*;
  logic [7:0] opt1;
  logic       css_en;
  ocd_osc_t   osc;
  logic       lvd_en;
  ocd_lvd_t   lvd;
  logic       halt_rst;
  logic       sw_dog;
  modport src (output opt1, input css_en, osc, lvd_en, lvd, halt_rst, sw_dog);
  modport dec (input opt1, output css_en, osc, lvd_en, lvd, halt_rst, sw_dog);
endinterface
`default_nettype wire

// *** src/ocd_opt_dec.sv ***
// Field decoder for the clock, supply and watchdog option byte
`include "ocd_regs.svh"
`default_nettype none
module ocd_opt_dec (
  ocd_cfg_if.dec cfg
);
  import ocd_pkg::*;

  logic [2:0] osc_f;
  logic [1:0] lvd_f;

  assign osc_f        = cfg.opt1[`OCD_B1_OSC_HI:`OCD_B1_OSC_LO];
  assign lvd_f        = cfg.opt1[`OCD_B1_LVD_HI:`OCD_B1_LVD_LO];
  assign cfg.css_en   = ~cfg.opt1[`OCD_B1_CSS];
  assign cfg.halt_rst = cfg.opt1[`OCD_B1_HALT];
  assign cfg.sw_dog   = cfg.opt1[`OCD_B1_SW];

  always_comb begin
    case (osc_f)
      `OCD_OSC_EXT_CLK: cfg.osc = OCD_OSC_EXT_CLK_T;
      `OCD_OSC_INT_RC:  cfg.osc = OCD_OSC_INT_RC_T;
      `OCD_OSC_EXT_RC0,
      `OCD_OSC_EXT_RC1: cfg.osc = OCD_OSC_EXT_RC_T;
      `OCD_OSC_LP:      cfg.osc = OCD_OSC_LP_T;
      `OCD_OSC_MP:      cfg.osc = OCD_OSC_MP_T;
      `OCD_OSC_MS:      cfg.osc = OCD_OSC_MS_T;
      `OCD_OSC_HS:      cfg.osc = OCD_OSC_HS_T;
      default:          cfg.osc = OCD_OSC_EXT_CLK_T;
    endcase
  end

  always_comb begin
    cfg.lvd_en = 1'b1;
    case (lvd_f)
      `OCD_LVD_OFF: begin
        cfg.lvd    = OCD_LVD_NONE_T;
        cfg.lvd_en = 1'b0;
      end
      `OCD_LVD_HIGH: cfg.lvd = OCD_LVD_HIGH_T;
      `OCD_LVD_MED:  cfg.lvd = OCD_LVD_MED_T;
      `OCD_LVD_LOW:  cfg.lvd = OCD_LVD_LOW_T;
      default: begin
        cfg.lvd    = OCD_LVD_NONE_T;
        cfg.lvd_en = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** src/ocd_top.sv ***
// Option byte storage, programming port, start-up decode and erase engine
`include "ocd_regs.svh"
`default_nettype none
module ocd_top #(
  parameter bit         FACTORY_CODED = 1'b0,
  parameter logic [7:0] FACTORY_OPT0  = 8'hFF,
  parameter logic [7:0] FACTORY_OPT1  = 8'hFF,
  parameter int         PMEM_BYTES    = `OCD_PMEM_BYTES
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      prog_mode,
  input  wire logic                      prog_sel,
  input  wire logic                      prog_wr,
  input  wire logic                      prog_rd,
  input  wire logic [7:0]                prog_wdata,
  output logic      [7:0]                prog_rdata,
  output logic                           prog_rvalid,
  output logic                           prog_wr_ack,
  output logic                           prog_wr_refused,
  input  wire logic                      ext_rd_req,
  input  wire logic                      ext_rd_eeprom,
  output logic                           ext_rd_grant,
  output logic                           ext_rd_block,
  input  wire logic [7:0]                pm_latch_data,
  output logic                           pm_erase_busy,
  output logic                           pm_wr_en,
  output logic      [`OCD_PMEM_AW-1:0]   pm_wr_addr,
  output logic      [7:0]                pm_wr_data,
  output logic                           cfg_valid,
  output logic                           pkg_64pin,
  output logic                           readout_protect,
  output logic                           css_enable,
  output var ocd_pkg::ocd_osc_t          main_clock_source_sel,
  output logic                           brownout_enable,
  output var ocd_pkg::ocd_lvd_t          brownout_threshold_sel,
  output logic                           reset_on_halt_entry,
  output logic                           dog_type_select
);
  import ocd_pkg::*;

  localparam logic [7:0] OPT0_INIT = FACTORY_CODED ? FACTORY_OPT0 : `OCD_OPT_RESET;
  localparam logic [7:0] OPT1_INIT = FACTORY_CODED ? FACTORY_OPT1 : `OCD_OPT_RESET;
  localparam logic [`OCD_PMEM_AW-1:0] ER_LAST = `OCD_PMEM_AW'(PMEM_BYTES - 1);

  // Option storage and programming port
  logic [7:0] opt0_r, opt0_nxt;
  logic [7:0] opt1_r, opt1_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       rvalid_r, rvalid_nxt;
  logic       ack_r, ack_nxt;
  logic       refused_r, refused_nxt;
  logic       wr_ok;
  logic       erase_req;

  // Start-up configuration
  logic       cfg_valid_r, cfg_valid_nxt;
  logic       pkg_r, pkg_nxt;
  logic       prot_r, prot_nxt;
  logic       css_r, css_nxt;
  ocd_osc_t   osc_r, osc_nxt;
  logic       lvd_en_r, lvd_en_nxt;
  ocd_lvd_t   lvd_r, lvd_nxt;
  logic       halt_r, halt_nxt;
  logic       sw_r, sw_nxt;

  // External read gate
  logic       grant_r, grant_nxt;
  logic       block_r, block_nxt;

  // Erase engine
  ocd_erase_st_t            er_st_r, er_st_nxt;
  logic [`OCD_PMEM_AW-1:0]  er_addr_r, er_addr_nxt;
  logic                     er_busy_r, er_busy_nxt;
  logic                     er_wen_r, er_wen_nxt;
  logic [7:0]               er_data_r, er_data_nxt;

  ocd_cfg_if cfg_bus ();

  ocd_opt_dec u_dec (
    .cfg (cfg_bus)
  );

  assign cfg_bus.opt1 = opt1_r;

  // Writes wait for the start-up load so the first decode always sees the reset contents of storage
  assign wr_ok = prog_wr & prog_mode & cfg_valid_r & ~er_busy_r
               & ~FACTORY_CODED;
  assign erase_req = wr_ok & (prog_sel == `OCD_SEL_OPT0)
                   & opt0_r[`OCD_B0_PROT] & ~prog_wdata[`OCD_B0_PROT];

  always_comb begin
    opt0_nxt    = opt0_r;
    opt1_nxt    = opt1_r;
    rdata_nxt   = rdata_r;
    rvalid_nxt  = 1'b0;
    ack_nxt     = wr_ok;
    refused_nxt = prog_wr & ~wr_ok;
    // Reserved bits are stored as given; the programmer keeps them at one
    if (wr_ok) begin
      if (prog_sel == `OCD_SEL_OPT0) begin
        opt0_nxt = prog_wdata;
      end else begin
        opt1_nxt = prog_wdata;
      end
    end
    if (prog_rd && prog_mode) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = (prog_sel == `OCD_SEL_OPT0) ? opt0_r : opt1_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt0_r    <= OPT0_INIT;
      opt1_r    <= OPT1_INIT;
      rdata_r   <= 8'h00;
      rvalid_r  <= 1'b0;
      ack_r     <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      opt0_r    <= opt0_nxt;
      opt1_r    <= opt1_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
      ack_r     <= ack_nxt;
      refused_r <= refused_nxt;
    end
  end

  // Settings are taken once after reset; later writes never reach them, as reset reloads storage
  always_comb begin
    cfg_valid_nxt = 1'b1;
    pkg_nxt       = pkg_r;
    prot_nxt      = prot_r;
    css_nxt       = css_r;
    osc_nxt       = osc_r;
    lvd_en_nxt    = lvd_en_r;
    lvd_nxt       = lvd_r;
    halt_nxt      = halt_r;
    sw_nxt        = sw_r;
    if (!cfg_valid_r) begin
      pkg_nxt    = opt0_r[`OCD_B0_PKG];
      prot_nxt   = opt0_r[`OCD_B0_PROT];
      css_nxt    = cfg_bus.css_en;
      osc_nxt    = cfg_bus.osc;
      lvd_en_nxt = cfg_bus.lvd_en;
      lvd_nxt    = cfg_bus.lvd;
      halt_nxt   = cfg_bus.halt_rst;
      sw_nxt     = cfg_bus.sw_dog;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_valid_r <= 1'b0;
      pkg_r       <= 1'b1;
      prot_r      <= 1'b1;
      css_r       <= 1'b0;
      osc_r       <= OCD_OSC_EXT_CLK_T;
      lvd_en_r    <= 1'b0;
      lvd_r       <= OCD_LVD_NONE_T;
      halt_r      <= 1'b1;
      sw_r        <= 1'b1;
    end else begin
      cfg_valid_r <= cfg_valid_nxt;
      pkg_r       <= pkg_nxt;
      prot_r      <= prot_nxt;
      css_r       <= css_nxt;
      osc_r       <= osc_nxt;
      lvd_en_r    <= lvd_en_nxt;
      lvd_r       <= lvd_nxt;
      halt_r      <= halt_nxt;
      sw_r        <= sw_nxt;
    end
  end

  // Live protection bit gates program memory, so a fresh clear cannot leak old code
  always_comb begin
    grant_nxt = 1'b0;
    block_nxt = 1'b0;
    if (ext_rd_req) begin
      if (ext_rd_eeprom) begin
        grant_nxt = ~er_busy_r;
        block_nxt = er_busy_r;
      end else if (opt0_r[`OCD_B0_PROT] || er_busy_r) begin
        block_nxt = 1'b1;
      end else begin
        grant_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      grant_r <= 1'b0;
      block_r <= 1'b0;
    end else begin
      grant_r <= grant_nxt;
      block_r <= block_nxt;
    end
  end

  // Erase sweeps every program byte; option storage is never addressed here
  always_comb begin
    er_st_nxt   = er_st_r;
    er_addr_nxt = er_addr_r;
    er_wen_nxt  = 1'b0;
    er_data_nxt = pm_latch_data;
    case (er_st_r)
      OCD_ER_IDLE: begin
        if (erase_req) begin
          er_st_nxt   = OCD_ER_RUN;
          er_addr_nxt = '0;
          er_wen_nxt  = 1'b1;
        end
      end
      OCD_ER_RUN: begin
        if (er_addr_r == ER_LAST) begin
          er_st_nxt = OCD_ER_IDLE;
        end else begin
          er_addr_nxt = er_addr_r + 1'b1;
          er_wen_nxt  = 1'b1;
        end
      end
      default: begin
        er_st_nxt = OCD_ER_IDLE;
      end
    endcase
    er_busy_nxt = (er_st_nxt == OCD_ER_RUN);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      er_st_r   <= OCD_ER_IDLE;
      er_addr_r <= '0;
      er_busy_r <= 1'b0;
      er_wen_r  <= 1'b0;
      er_data_r <= 8'h00;
    end else begin
      er_st_r   <= er_st_nxt;
      er_addr_r <= er_addr_nxt;
      er_busy_r <= er_busy_nxt;
      er_wen_r  <= er_wen_nxt;
      er_data_r <= er_data_nxt;
    end
  end

  assign prog_rdata             = rdata_r;
  assign prog_rvalid            = rvalid_r;
  assign prog_wr_ack            = ack_r;
  assign prog_wr_refused        = refused_r;
  assign ext_rd_grant           = grant_r;
  assign ext_rd_block           = block_r;
  assign pm_erase_busy          = er_busy_r;
  assign pm_wr_en               = er_wen_r;
  assign pm_wr_addr             = er_addr_r;
  assign pm_wr_data             = er_data_r;
  assign cfg_valid              = cfg_valid_r;
  assign pkg_64pin              = pkg_r;
  assign readout_protect        = prot_r;
  assign css_enable             = css_r;
  assign main_clock_source_sel  = osc_r;
  assign brownout_enable        = lvd_en_r;
  assign brownout_threshold_sel = lvd_r;
  assign reset_on_halt_entry    = halt_r;
  assign dog_type_select        = sw_r;

  default clocking ast_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_NO_ACCESS_OUTSIDE_PROG: assert property (
    (prog_rd && !prog_mode) |=> !prog_rvalid ##0 !prog_wr_ack)
    else $error("option byte reached outside programming mode");

  AST_ERASED_READS_ONES: assert property (
    (!cfg_valid_r && !FACTORY_CODED) |-> (opt0_r == 8'hFF && opt1_r == 8'hFF))
    else $error("unprogrammed option storage not all ones");

  AST_PKG_AND_PROT_LOAD: assert property (
    $rose(cfg_valid_r) |-> (pkg_64pin == $past(opt0_r[1]))
                        && (readout_protect == $past(opt0_r[0])))
    else $error("package or protection option loaded wrong");

  AST_PROTECT_BLOCKS_PMEM: assert property (
    (ext_rd_req && !ext_rd_eeprom && opt0_r[0]) |=> (ext_rd_block && !ext_rd_grant))
    else $error("protected program memory was readable");

  AST_EEPROM_NOT_PROTECTED: assert property (
    (ext_rd_req && ext_rd_eeprom && opt0_r[0] && !er_busy_r && !erase_req)
    |=> (ext_rd_grant && !ext_rd_block))
    else $error("protection blocked a data EEPROM read");

  AST_ERASE_ON_CLEAR: assert property (
    (prog_wr && prog_mode && cfg_valid_r && !er_busy_r && !FACTORY_CODED
     && prog_sel == 1'b0 && opt0_r[0] && !prog_wdata[0])
    |=> (pm_erase_busy && pm_wr_en && pm_wr_addr == 14'h0000) ##1 (pm_wr_addr == 14'h0001))
    else $error("clearing protection did not start the erase sweep");

  AST_ERASE_KEEPS_OPTIONS: assert property (
    pm_erase_busy |=> ($stable(opt1_r) && !opt0_r[0]))
    else $error("option bytes changed during erase");

  AST_CLOCK_WATCHDOG_LOAD: assert property (
    $rose(cfg_valid_r) |-> (css_enable == !$past(opt1_r[7]))
                        && (reset_on_halt_entry == $past(opt1_r[1]))
                        && (dog_type_select == $past(opt1_r[0])))
    else $error("clock security or watchdog option loaded wrong");

  AST_OSC_DECODE: assert property (
    ($rose(cfg_valid_r) && $past(opt1_r[6:5]) == 2'b10)
    |-> (main_clock_source_sel == OCD_OSC_EXT_RC_T))
    else $error("external RC oscillator code decoded wrong");

  AST_LVD_DECODE: assert property (
    $rose(cfg_valid_r) |-> (brownout_enable == ($past(opt1_r[3:2]) != 2'b11)))
    else $error("brownout enable decoded wrong");

  AST_FACTORY_FIXED: assert property (
    (FACTORY_CODED && prog_wr) |=> (prog_wr_refused && opt0_r == FACTORY_OPT0
                                    && opt1_r == FACTORY_OPT1))
    else $error("factory coded option accepted a write");

  COV_WRITE_ACCEPTED: cover property (prog_wr && prog_mode ##1 prog_wr_ack);
  COV_PMEM_BLOCKED: cover property (ext_rd_req && !ext_rd_eeprom ##1 ext_rd_block);
  COV_ERASE_DONE: cover property ($fell(pm_erase_busy));
endmodule
`default_nettype wire

// *** testbench/ocd_prog_tool.sv ***
// Programming tool model that drives the option byte port
`default_nettype none
module ocd_prog_tool (
  input  wire logic       ref_clk,
  output logic            prog_mode,
  output logic            prog_sel,
  output logic            prog_wr,
  output logic            prog_rd,
  output logic [7:0]      prog_wdata,
  input  wire logic [7:0] prog_rdata,
  input  wire logic       prog_rvalid,
  input  wire logic       prog_wr_ack,
  input  wire logic       prog_wr_refused
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    prog_mode  = 1'b0;
    prog_sel   = 1'b0;
    prog_wr    = 1'b0;
    prog_rd    = 1'b0;
    prog_wdata = 8'h00;
  end

  // Byte access uses whatever mode line the caller has set, raised or not
  task automatic mode(input logic m);
    prog_mode = m;
  endtask

  // Called just after a falling edge; strobe spans exactly one rising edge
  task automatic wr(input logic sel, input logic [7:0] d, output logic ack, output logic rf);
    prog_sel   = sel;
    prog_wdata = sel ? d : {6'h3F, d[1:0]}; // Reserved bits always written as ones
    prog_wr    = 1'b1;
    @(negedge ref_clk);
    prog_wr    = 1'b0;
    // Data line shows garbage once the strobe is gone, never the held value
    prog_wdata = ~prog_wdata;
    ack        = prog_wr_ack;
    rf         = prog_wr_refused;
  endtask

  task automatic rd(input logic sel, output logic v, output logic [7:0] d);
    prog_sel = sel;
    prog_rd  = 1'b1;
    @(negedge ref_clk);
    prog_rd  = 1'b0;
    v        = prog_rvalid;
    d        = prog_rdata;
  endtask
endmodule
`default_nettype wire

// *** testbench/option_byte_config_decoder_tb.sv ***
// Self-checking bench for the option byte decoder
`default_nettype none
module option_byte_config_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ocd_pkg::*;

  logic           ref_clk, rst_n, prog_mode, prog_sel, prog_wr, prog_rd;
  logic [7:0]     prog_wdata, prog_rdata, pm_latch_data, pm_wr_data;
  logic           prog_rvalid, prog_wr_ack, prog_wr_refused;
  logic           ext_rd_req, ext_rd_eeprom, ext_rd_grant, ext_rd_block;
  logic           pm_erase_busy, pm_wr_en, cfg_valid, pkg_64pin, readout_protect;
  logic [13:0]    pm_wr_addr;
  logic           css_enable, brownout_enable, reset_on_halt_entry, dog_type_select;
  ocd_osc_t       main_clock_source_sel;
  ocd_lvd_t       brownout_threshold_sel;
  logic [7:0]     f_rdata [8];
  logic           f_ref [8], f_pkg [8], f_prot [8], f_css [8], f_bo [8], f_halt [8], f_sw [8];
  ocd_osc_t       f_osc [8];
  ocd_lvd_t       f_lvd [8];
  int             errors, checks;
  logic           a, b;
  logic [7:0]     d;

  ocd_prog_tool u_tool (.ref_clk(ref_clk), .prog_mode(prog_mode), .prog_sel(prog_sel),
    .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .prog_rvalid(prog_rvalid), .prog_wr_ack(prog_wr_ack), .prog_wr_refused(prog_wr_refused));

  ocd_top #(.PMEM_BYTES(16)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .prog_mode(prog_mode),
    .prog_sel(prog_sel), .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_wdata(prog_wdata),
    .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid), .prog_wr_ack(prog_wr_ack),
    .prog_wr_refused(prog_wr_refused), .ext_rd_req(ext_rd_req), .ext_rd_eeprom(ext_rd_eeprom),
    .ext_rd_grant(ext_rd_grant), .ext_rd_block(ext_rd_block), .pm_latch_data(pm_latch_data),
    .pm_erase_busy(pm_erase_busy), .pm_wr_en(pm_wr_en), .pm_wr_addr(pm_wr_addr),
    .pm_wr_data(pm_wr_data), .cfg_valid(cfg_valid), .pkg_64pin(pkg_64pin),
    .readout_protect(readout_protect), .css_enable(css_enable),
    .main_clock_source_sel(main_clock_source_sel), .brownout_enable(brownout_enable),
    .brownout_threshold_sel(brownout_threshold_sel),
    .reset_on_halt_entry(reset_on_halt_entry), .dog_type_select(dog_type_select));

  // Factory parts cover every field code, since user storage reloads FF at each reset
  for (genvar gi = 0; gi < 8; gi++) begin : g_fac
    localparam logic [2:0] C = 3'(gi);
    ocd_top #(.FACTORY_CODED(1'b1), .FACTORY_OPT0({6'h3F, C[1:0]}),
      .FACTORY_OPT1({C[0], C, C[1:0], C[0], ~C[0]})) u_fac (
      .ref_clk(ref_clk), .rst_n(rst_n), .prog_mode(prog_mode), .prog_sel(prog_sel),
      .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_wdata(prog_wdata),
      .prog_rdata(f_rdata[gi]), .prog_rvalid(), .prog_wr_ack(), .prog_wr_refused(f_ref[gi]),
      .ext_rd_req(ext_rd_req), .ext_rd_eeprom(ext_rd_eeprom), .ext_rd_grant(),
      .ext_rd_block(), .pm_latch_data(pm_latch_data), .pm_erase_busy(), .pm_wr_en(),
      .pm_wr_addr(), .pm_wr_data(), .cfg_valid(), .pkg_64pin(f_pkg[gi]),
      .readout_protect(f_prot[gi]), .css_enable(f_css[gi]),
      .main_clock_source_sel(f_osc[gi]), .brownout_enable(f_bo[gi]),
      .brownout_threshold_sel(f_lvd[gi]), .reset_on_halt_entry(f_halt[gi]),
      .dog_type_select(f_sw[gi]));
  end

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic ext(input logic ee, output logic gr, output logic bl);
    ext_rd_eeprom = ee;
    ext_rd_req    = 1'b1;
    @(negedge ref_clk);
    ext_rd_req    = 1'b0;
    gr            = ext_rd_grant;
    bl            = ext_rd_block;
  endtask

  task automatic t_start;
    chk(8'(cfg_valid), 8'h01);
    chk(8'(pkg_64pin), 8'h01);
    chk(8'(readout_protect), 8'h01);
    chk(8'(css_enable), 8'h00);
    chk(8'(main_clock_source_sel), 8'(OCD_OSC_EXT_CLK_T));
    chk(8'(brownout_enable), 8'h00);
    chk(8'(brownout_threshold_sel), 8'(OCD_LVD_NONE_T));
    chk(8'(reset_on_halt_entry), 8'h01);
    chk(8'(dog_type_select), 8'h01);
  endtask

  task automatic t_blank;
    u_tool.mode(1'b1);
    u_tool.rd(1'b0, a, d);
    chk(8'(a), 8'h01);
    chk(d, 8'hFF);
    // A free edge between strobes, so no line is driven twice in one step
    @(negedge ref_clk);
    u_tool.rd(1'b1, a, d);
    chk(d, 8'hFF);
    for (int i = 0; i < 8; i++) chk(f_rdata[i], {i[0], i[2:0], i[1:0], i[0], ~i[0]});
  endtask

  task automatic t_mode;
    u_tool.mode(1'b0);
    u_tool.wr(1'b1, 8'h00, a, b);
    chk(8'({a, b}), 8'h01);
    u_tool.rd(1'b1, a, d);
    chk(8'(a), 8'h00);
    u_tool.mode(1'b1);
  endtask

  task automatic t_rw;
    u_tool.wr(1'b1, 8'h5A, a, b);
    chk(8'({a, b}), 8'h02);
    for (int i = 0; i < 8; i++) chk(8'(f_ref[i]), 8'h01);
    u_tool.rd(1'b1, a, d);
    chk(d, 8'h5A);
    u_tool.wr(1'b0, 8'h01, a, b);
    u_tool.rd(1'b0, a, d);
    chk(d, 8'hFD);
    ext(1'b0, a, b);
    chk(8'({a, b}), 8'h01);
    @(negedge ref_clk);
    ext(1'b1, a, b);
    chk(8'({a, b}), 8'h02);
  endtask

  task automatic t_erase;
    u_tool.wr(1'b0, 8'h00, a, b);
    chk(8'({a, pm_erase_busy, pm_wr_en}), 8'h07);
    chk(8'(pm_wr_addr), 8'h00);
    chk(pm_wr_data, 8'hA5);
    // Latch contents move every cycle so a misaligned data capture shows up
    pm_latch_data = 8'h51;
    for (int k = 1; k < 16; k++) begin
      if (k == 2) begin
        // Write in mid-sweep must bounce and leave the sweep running
        u_tool.wr(1'b0, 8'hFF, a, b);
        chk(8'({a, b}), 8'h01);
      end else begin
        @(negedge ref_clk);
      end
      chk({pm_erase_busy, pm_wr_en, 6'(k)}, 8'(8'hC0 | k));
      chk(pm_wr_data, 8'(8'h50 + k));
      chk(8'(pm_wr_addr), 8'(k));
      pm_latch_data = 8'(8'h51 + k);
    end
    @(negedge ref_clk);
    chk(8'({pm_erase_busy, pm_wr_en}), 8'h00);
    u_tool.rd(1'b1, a, d);
    chk(d, 8'h5A);
    @(negedge ref_clk);
    u_tool.rd(1'b0, a, d);
    chk(d, 8'hFC);
    ext(1'b0, a, b);
    chk(8'({a, b}), 8'h02);
  endtask

  function automatic ocd_osc_t exp_osc(input logic [2:0] c);
    case (c)
      3'h7: return OCD_OSC_EXT_CLK_T;
      3'h6: return OCD_OSC_INT_RC_T;
      3'h5, 3'h4: return OCD_OSC_EXT_RC_T;
      3'h3: return OCD_OSC_LP_T;
      3'h2: return OCD_OSC_MP_T;
      3'h1: return OCD_OSC_MS_T;
      default: return OCD_OSC_HS_T;
    endcase
  endfunction

  function automatic ocd_lvd_t exp_lvd(input logic [1:0] c);
    case (c)
      2'h3: return OCD_LVD_NONE_T;
      2'h2: return OCD_LVD_HIGH_T;
      2'h1: return OCD_LVD_MED_T;
      default: return OCD_LVD_LOW_T;
    endcase
  endfunction

  task automatic t_decode;
    for (int i = 0; i < 8; i++) begin
      chk(8'(f_pkg[i]), 8'(i[1]));
      chk(8'(f_prot[i]), 8'(i[0]));
      chk(8'(f_css[i]), {7'h00, ~i[0]});
      chk(8'(f_osc[i]), 8'(exp_osc(i[2:0])));
      chk(8'(f_bo[i]), 8'(i[1:0] != 2'h3));
      chk(8'(f_lvd[i]), 8'(exp_lvd(i[1:0])));
      chk(8'(f_halt[i]), 8'(i[0]));
      chk(8'(f_sw[i]), {7'h00, ~i[0]});
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    stop_test();
  end

  initial begin
    errors        = 0;
    checks        = 0;
    rst_n         = 1'b0;
    ext_rd_req    = 1'b0;
    ext_rd_eeprom = 1'b0;
    pm_latch_data = 8'hA5;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    t_start();
    t_decode();
    t_blank();
    t_mode();
    t_rw();
    t_erase();
    // Storage models erased cells, so a fresh reset brings back all ones
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    t_start();
    u_tool.rd(1'b1, a, d);
    chk(d, 8'hFF);
    stop_test();
  end
endmodule
`default_nettype wire
